// ---- hw/run_mode_pkg.sv ----
package run_mode_pkg;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int unsigned CLOCK_HZ         = 250_000_000;
    localparam int unsigned STROBE_MIN_MS    = 10;
    // strobe must exceed 10 ms: one cycle beyond the minimum
    localparam int unsigned STROBE_MIN_CYCLES = (CLOCK_HZ / 1000) * STROBE_MIN_MS + 1;

    // --------------------------------------------------------------
    // widths and encodings
    // --------------------------------------------------------------
    localparam int unsigned STEP_W   = 6;
    localparam int unsigned SPEED_W  = 2;
    localparam int unsigned OPCODE_W = 4;

    localparam logic [OPCODE_W-1:0] OP_ORIGIN_MOVE    = 4'h1;
    localparam logic [OPCODE_W-1:0] OP_RELATIVE_MOVE  = 4'h2;
    localparam logic [OPCODE_W-1:0] OP_LINE_INTERP    = 4'h3;
    localparam logic [OPCODE_W-1:0] OP_CIRC_INTERP    = 4'h4;
    localparam logic [OPCODE_W-1:0] OP_FULL_CIRCLE    = 4'h5;
    localparam logic [OPCODE_W-1:0] OP_ARC_INTERP     = 4'h6;

    // request kinds to the pulse engine
    localparam logic [2:0] REQ_NONE    = 3'h0;
    localparam logic [2:0] REQ_INDEX   = 3'h1;
    localparam logic [2:0] REQ_PROGRAM = 3'h2;

    // register map
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK   = 4'h4;
    localparam logic [3:0] ADDR_STATE  = 4'h8;
    localparam int unsigned EV_W       = 4;
    localparam int unsigned EV_INDEX   = 0;
    localparam int unsigned EV_PROGRAM = 1;
    localparam int unsigned EV_ERROR   = 2;
    localparam int unsigned EV_STOP    = 3;
    localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

    typedef enum logic [1:0] {
        MODE_INDEX,
        MODE_JOG,
        MODE_CONT,
        MODE_PROGRAM
    } run_mode_t;

endpackage

// ---- hw/pin_sync_if.sv ----
`timescale 1ns/100ps
interface pin_sync_if #(parameter int unsigned W = 16);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface

// ---- hw/pin_synchronizer.sv ----
`timescale 1ns/100ps
module pin_synchronizer #(
    parameter int unsigned W = 16
) (
    // clock and reset
    input wire logic   clock,
    input wire logic   reset_n,
    // pins
    pin_sync_if.sync   pins
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= pins.raw;
            sync_r <= meta_r;
        end
    end

    assign pins.synced = sync_r;
endmodule

// ---- hw/strobe_qualifier.sv ----
`timescale 1ns/100ps
module strobe_qualifier #(
    parameter int unsigned MIN_CYCLES = run_mode_pkg::STROBE_MIN_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // strobe level, already synchronised
    input  wire logic strobe,
    // one pulse once strobe exceeds the minimum
    output logic      accepted
);
    localparam int unsigned CW = $clog2(MIN_CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(MIN_CYCLES);

    logic [CW-1:0] count_r;

    // short strobes never reach the limit and are dropped
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r  <= '0;
            accepted <= 1'b0;
        end else begin
            accepted <= 1'b0;
            if (!strobe) begin
                count_r <= '0;
            end else if (count_r != LIMIT) begin
                count_r <= count_r + CW'(1);
                if (count_r == LIMIT - CW'(1)) begin
                    accepted <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- hw/parallel_run_mode_decoder.sv ----
// Operation
// - both mode selects off: index mode, strobe runs one stored step
// - low select on, high off: jog; jog variant input picks variant one or two
// - low off, high on: continuous mode, started by one direction activation
// - both mode selects on: program mode, runs program from start step on strobe
// - start step is six select bits binary, bit5 most significant, 0..63
// - strobe held over 10 ms runs the selected step
// - index step must be a move or interpolation command, else error
// - outside jog two, only axes whose select input is active are driven
// - jog pulses only while run input held, stops on release
// - jog one: selected axes all move in shared run direction
// - jog two: four independent x/y forward and reverse inputs
// - two speed bits pick one of four speeds, changeable mid-drive
// - continuous drive runs until stop or limit in travel direction
`timescale 1ns/100ps
module parallel_run_mode_decoder #(
    parameter int unsigned STROBE_CYCLES = run_mode_pkg::STROBE_MIN_CYCLES
) (
    // clock and reset
    input  wire logic                                   clock,
    input  wire logic                                   reset_n,
    // parallel port pins (level, asynchronous)
    input  wire logic                                   mode_select_low,
    input  wire logic                                   mode_select_high,
    input  wire logic                                   jog_variant,
    input  wire logic                                   strobe_pin,
    input  wire logic                                   axis_x_pin,
    input  wire logic                                   axis_y_pin,
    input  wire logic [run_mode_pkg::STEP_W-1:0]        step_select_pins,
    input  wire logic                                   stop_pin,
    input  wire logic                                   limit_fwd_x,
    input  wire logic                                   limit_rev_x,
    input  wire logic                                   limit_fwd_y,
    input  wire logic                                   limit_rev_y,
    // stored program opcode lookup (same clock)
    output logic [run_mode_pkg::STEP_W-1:0]             opcode_step,
    input  wire logic [run_mode_pkg::OPCODE_W-1:0]      opcode_data,
    // requests to the pulse engine
    output logic [2:0]                                  step_req,
    output logic [run_mode_pkg::STEP_W-1:0]             step_num,
    output logic [1:0]                                  step_axes,
    output logic                                        x_fwd,
    output logic                                        x_rev,
    output logic                                        y_fwd,
    output logic                                        y_rev,
    output logic [run_mode_pkg::SPEED_W-1:0]            speed_sel,
    output logic [1:0]                                  run_mode,
    // register port
    input  wire logic [3:0]                             reg_addr,
    input  wire logic [31:0]                            reg_wdata,
    input  wire logic                                   reg_write,
    input  wire logic                                   reg_read,
    output logic [31:0]                                 reg_rdata,
    output logic                                        irq
);
    localparam int unsigned NPIN = 17;

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    pin_sync_if #(.W(NPIN)) pins ();
    assign pins.raw = {mode_select_low, mode_select_high, jog_variant, strobe_pin,
                       axis_x_pin, axis_y_pin, step_select_pins, stop_pin,
                       limit_fwd_x, limit_rev_x, limit_fwd_y, limit_rev_y};

    pin_synchronizer #(.W(NPIN)) u_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .pins    (pins)
    );

    logic       m_low, m_high, jog2, strobe_s, ax_x, ax_y, stop_s;
    logic       lfx, lrx, lfy, lry;
    logic [5:0] step_s;
    assign {m_low, m_high, jog2, strobe_s, ax_x, ax_y, step_s, stop_s,
            lfx, lrx, lfy, lry} = pins.synced;

    // shared pins: step bits double as run and speed inputs
    logic run_f, run_r;
    logic [1:0] speed_s;
    assign run_f   = step_s[0];
    assign run_r   = step_s[1];
    assign speed_s = step_s[3:2];

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    run_mode_pkg::run_mode_t mode;
    always_comb begin
        case ({m_high, m_low})
            2'b00:   mode = run_mode_pkg::MODE_INDEX;
            2'b01:   mode = run_mode_pkg::MODE_JOG;
            2'b10:   mode = run_mode_pkg::MODE_CONT;
            2'b11:   mode = run_mode_pkg::MODE_PROGRAM;
            default: mode = run_mode_pkg::MODE_INDEX;
        endcase
    end

    function automatic logic valid_index_op(input logic [run_mode_pkg::OPCODE_W-1:0] op);
        valid_index_op = (op == run_mode_pkg::OP_ORIGIN_MOVE)   ||
                         (op == run_mode_pkg::OP_RELATIVE_MOVE) ||
                         (op == run_mode_pkg::OP_LINE_INTERP)   ||
                         (op == run_mode_pkg::OP_CIRC_INTERP)   ||
                         (op == run_mode_pkg::OP_FULL_CIRCLE)   ||
                         (op == run_mode_pkg::OP_ARC_INTERP);
    endfunction

    // ----------------------------------------------------------------
    // strobe qualification
    // ----------------------------------------------------------------
    logic accepted;
    strobe_qualifier #(.MIN_CYCLES(STROBE_CYCLES)) u_strobe (
        .clock    (clock),
        .reset_n  (reset_n),
        .strobe   (strobe_s),
        .accepted (accepted)
    );

    // ----------------------------------------------------------------
    // step launch: sample, look up opcode, then issue or flag error
    // ----------------------------------------------------------------
    logic       pending_r;
    logic       pend_index_r;
    logic [1:0] pend_axes_r;
    logic       ev_index, ev_program, ev_error, ev_stop;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pending_r    <= 1'b0;
            pend_index_r <= 1'b0;
            pend_axes_r  <= 2'b00;
            opcode_step  <= '0;
        end else begin
            pending_r <= 1'b0;
            if (accepted && (mode == run_mode_pkg::MODE_INDEX || mode == run_mode_pkg::MODE_PROGRAM)) begin
                opcode_step  <= step_s;
                pend_axes_r  <= {ax_y, ax_x};
                pend_index_r <= (mode == run_mode_pkg::MODE_INDEX);
                pending_r    <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            step_req  <= run_mode_pkg::REQ_NONE;
            step_num  <= '0;
            step_axes <= 2'b00;
        end else begin
            step_req <= run_mode_pkg::REQ_NONE;
            if (pending_r) begin
                step_num  <= opcode_step;
                step_axes <= pend_axes_r;
                if (!pend_index_r) begin
                    step_req <= run_mode_pkg::REQ_PROGRAM;
                end else if (valid_index_op(opcode_data)) begin
                    step_req <= run_mode_pkg::REQ_INDEX;
                end
            end
        end
    end

    assign ev_index   = pending_r && pend_index_r && valid_index_op(opcode_data);
    assign ev_error   = pending_r && pend_index_r && !valid_index_op(opcode_data);
    assign ev_program = pending_r && !pend_index_r;

    // ----------------------------------------------------------------
    // continuous drive latch
    // ----------------------------------------------------------------
    logic cont_on_r, cont_dir_r;
    logic [1:0] cont_axes_r;
    logic run_f_d_r, run_r_d_r;
    logic cont_limit;
    assign cont_limit = cont_dir_r ? ((cont_axes_r[0] && lrx) || (cont_axes_r[1] && lry))
                                   : ((cont_axes_r[0] && lfx) || (cont_axes_r[1] && lfy));
    assign ev_stop = cont_on_r && (stop_s || cont_limit || mode != run_mode_pkg::MODE_CONT);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            run_f_d_r   <= 1'b0;
            run_r_d_r   <= 1'b0;
            cont_on_r   <= 1'b0;
            cont_dir_r  <= 1'b0;
            cont_axes_r <= 2'b00;
        end else begin
            run_f_d_r <= run_f;
            run_r_d_r <= run_r;
            if (ev_stop) begin
                cont_on_r <= 1'b0;
            end else if (!cont_on_r && mode == run_mode_pkg::MODE_CONT && !stop_s
                         && ((run_f && !run_f_d_r) || (run_r && !run_r_d_r))) begin
                cont_on_r   <= 1'b1;
                cont_dir_r  <= !(run_f && !run_f_d_r);
                cont_axes_r <= {ax_y, ax_x};
            end
        end
    end

    // ----------------------------------------------------------------
    // direction outputs and speed
    // ----------------------------------------------------------------
    logic xf_nxt, xr_nxt, yf_nxt, yr_nxt;
    always_comb begin
        xf_nxt = 1'b0;
        xr_nxt = 1'b0;
        yf_nxt = 1'b0;
        yr_nxt = 1'b0;
        case (mode)
            run_mode_pkg::MODE_JOG: begin
                if (jog2) begin
                    xf_nxt = run_f && !run_r;
                    xr_nxt = run_r && !run_f;
                    yf_nxt = ax_x && !ax_y;
                    yr_nxt = ax_y && !ax_x;
                end else if (run_f != run_r) begin
                    xf_nxt = ax_x && run_f;
                    xr_nxt = ax_x && run_r;
                    yf_nxt = ax_y && run_f;
                    yr_nxt = ax_y && run_r;
                end
            end
            run_mode_pkg::MODE_CONT: begin
                if (cont_on_r && !ev_stop) begin
                    xf_nxt = cont_axes_r[0] && !cont_dir_r;
                    xr_nxt = cont_axes_r[0] && cont_dir_r;
                    yf_nxt = cont_axes_r[1] && !cont_dir_r;
                    yr_nxt = cont_axes_r[1] && cont_dir_r;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            x_fwd     <= 1'b0;
            x_rev     <= 1'b0;
            y_fwd     <= 1'b0;
            y_rev     <= 1'b0;
            speed_sel <= '0;
            run_mode  <= 2'b00;
        end else begin
            x_fwd     <= xf_nxt;
            x_rev     <= xr_nxt;
            y_fwd     <= yf_nxt;
            y_rev     <= yr_nxt;
            speed_sel <= speed_s;
            run_mode  <= mode;
        end
    end

    // ----------------------------------------------------------------
    // status, mask, interrupt
    // ----------------------------------------------------------------
    logic [run_mode_pkg::EV_W-1:0] status_r, mask_r, events, clr;
    assign events = {ev_stop, ev_error, ev_program, ev_index};
    assign clr    = (reg_write && reg_addr == run_mode_pkg::ADDR_STATUS)
                    ? reg_wdata[run_mode_pkg::EV_W-1:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= '0;
            mask_r   <= run_mode_pkg::MASK_RESET;
            irq      <= 1'b0;
        end else begin
            status_r <= (status_r & ~clr) | events;
            if (reg_write && reg_addr == run_mode_pkg::ADDR_MASK) begin
                mask_r <= reg_wdata[run_mode_pkg::EV_W-1:0];
            end
            irq <= |(((status_r & ~clr) | events) & mask_r);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000;
            if (reg_read) begin
                case (reg_addr)
                    run_mode_pkg::ADDR_STATUS: reg_rdata <= {28'h000_0000, status_r};
                    run_mode_pkg::ADDR_MASK:   reg_rdata <= {28'h000_0000, mask_r};
                    run_mode_pkg::ADDR_STATE:  reg_rdata <= {25'h000_0000, cont_on_r, cont_dir_r,
                                                             x_fwd, x_rev, y_fwd, y_rev, pending_r};
                    default:                   reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ---- testbench/program_store_model.sv ----
`timescale 1ns/100ps
module program_store_model (
    // clock
    input  wire logic       clock,
    // opcode lookup
    input  wire logic [5:0] opcode_step,
    output logic      [3:0] opcode_data
);
    // low three step bits name the opcode: entries 0 and 7 hold no move
    // combinational, so the opcode stands in the same cycle as the step changes
    always_comb begin
        opcode_data = {1'b0, opcode_step[2:0]};
    end
endmodule

// ---- testbench/run_mode_checker.sv ----
`timescale 1ns/100ps
module run_mode_checker #(
    parameter int unsigned STROBE_CYCLES = run_mode_pkg::STROBE_MIN_CYCLES
) (
    // clock and reset
    input wire logic       clock,
    input wire logic       reset_n,
    // pins
    input wire logic       mode_select_low,
    input wire logic       mode_select_high,
    input wire logic       jog_variant,
    input wire logic       strobe_pin,
    input wire logic       axis_x_pin,
    input wire logic       axis_y_pin,
    input wire logic       stop_pin,
    input wire logic [5:0] step_select_pins,
    // engine requests
    input wire logic [2:0] step_req,
    input wire logic [5:0] step_num,
    input wire logic [1:0] step_axes,
    input wire logic       x_fwd,
    input wire logic       x_rev,
    input wire logic       y_fwd,
    input wire logic       y_rev,
    input wire logic [1:0] speed_sel,
    input wire logic [1:0] run_mode,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic       reg_write,
    input wire logic       irq
);
    logic [31:0] run_len;
    logic        strobe_q;
    logic        mask_wr;
    logic [3:0]  drives;
    assign drives = {x_fwd, x_rev, y_fwd, y_rev};

    // run length kept after the fall, since the request lands later
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            run_len  <= '0;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= strobe_pin;
            if (strobe_pin) begin
                run_len <= strobe_q ? run_len + 32'h1 : 32'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) mask_wr <= 1'b0;
        else if (reg_write && reg_addr == run_mode_pkg::ADDR_MASK) mask_wr <= 1'b1;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    req_pulse_a: assert property (step_req != '0 |=> step_req == '0)
        else $error("request wider than one cycle");
    strobe_len_a: assert property (step_req != '0 |-> run_len >= STROBE_CYCLES)
        else $error("request after short strobe");
    index_req_a: assert property (step_req == run_mode_pkg::REQ_INDEX |-> run_mode == 2'd0)
        else $error("index request outside index mode");
    prog_req_a: assert property (step_req == run_mode_pkg::REQ_PROGRAM |-> run_mode == 2'd3)
        else $error("program request outside program mode");
    mode_map_a: assert property (($stable(mode_select_low) && $stable(mode_select_high))[*5]
        |-> run_mode == {mode_select_high, mode_select_low}) else $error("mode decode wrong");
    step_sample_a: assert property (($stable({step_select_pins, axis_y_pin, axis_x_pin})[*8]
        ##0 step_req != '0) |-> step_num == step_select_pins && step_axes == {axis_y_pin, axis_x_pin})
        else $error("step or axes sampled wrong");
    jog_idle_a: assert property ((run_mode == 2'd1 && step_select_pins[1:0] == 2'b00
        && !axis_x_pin && !axis_y_pin)[*5] |-> drives == 4'h0) else $error("jog moves without run input");
    jog_two_a: assert property ((run_mode == 2'd1 && jog_variant && !stop_pin
        && step_select_pins[1:0] == 2'b10 && axis_x_pin && !axis_y_pin)[*5] |-> drives == 4'h6)
        else $error("independent jog inputs misrouted");
    speed_a: assert property (((run_mode == 2'd1 || run_mode == 2'd2)
        && $stable(step_select_pins[3:2]))[*5] |-> speed_sel == step_select_pins[3:2])
        else $error("speed select not followed");
    cont_stop_a: assert property ((run_mode == 2'd2 && stop_pin)[*5] |-> drives == 4'h0)
        else $error("continuous drive ignores stop");
    halt_modes_a: assert property ((run_mode == 2'd0 || run_mode == 2'd3)[*4] |-> drives == 4'h0)
        else $error("drive active in index or program mode");
    irq_mask_a: assert property (!mask_wr |-> !irq)
        else $error("interrupt with reset mask");

    cover property (step_req == run_mode_pkg::REQ_INDEX);
    cover property (step_req == run_mode_pkg::REQ_PROGRAM);
    cover property (irq);
endmodule

bind parallel_run_mode_decoder run_mode_checker #(.STROBE_CYCLES(STROBE_CYCLES)) chk (
    .clock(clock), .reset_n(reset_n), .mode_select_low(mode_select_low),
    .mode_select_high(mode_select_high), .jog_variant(jog_variant), .strobe_pin(strobe_pin),
    .axis_x_pin(axis_x_pin), .axis_y_pin(axis_y_pin), .stop_pin(stop_pin),
    .step_select_pins(step_select_pins), .step_req(step_req), .step_num(step_num),
    .step_axes(step_axes), .x_fwd(x_fwd), .x_rev(x_rev), .y_fwd(y_fwd), .y_rev(y_rev),
    .speed_sel(speed_sel), .run_mode(run_mode), .reg_addr(reg_addr), .reg_write(reg_write), .irq(irq)
);

// ---- testbench/tb_parallel_run_mode_decoder.sv ----
`timescale 1ns/100ps
module tb_parallel_run_mode_decoder;
    localparam int unsigned STROBE_LEN = 8;
    localparam logic [3:0]  ST = run_mode_pkg::ADDR_STATUS;
    localparam logic [3:0]  MK = run_mode_pkg::ADDR_MASK;
    logic        clock, reset_n, mode_select_low, mode_select_high, jog_variant;
    logic        strobe_pin, axis_x_pin, axis_y_pin, stop_pin, limit_fwd_x;
    logic        reg_write, reg_read, irq, x_fwd, x_rev, y_fwd, y_rev;
    logic [5:0]  step_select_pins, opcode_step, step_num;
    logic [3:0]  opcode_data, reg_addr;
    logic [2:0]  step_req, got_req;
    logic [1:0]  step_axes, speed_sel, run_mode;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0]  steps [4] = '{6'h0a, 6'h3f, 6'h21, 6'h00};
    int          miscompares, total_checks, i;

    parallel_run_mode_decoder #(.STROBE_CYCLES(STROBE_LEN)) dut (
        .clock(clock), .reset_n(reset_n), .mode_select_low(mode_select_low),
        .mode_select_high(mode_select_high), .jog_variant(jog_variant), .strobe_pin(strobe_pin),
        .axis_x_pin(axis_x_pin), .axis_y_pin(axis_y_pin), .step_select_pins(step_select_pins),
        .stop_pin(stop_pin), .limit_fwd_x(limit_fwd_x), .limit_rev_x(1'b0), .limit_fwd_y(1'b0),
        .limit_rev_y(1'b0), .opcode_step(opcode_step), .opcode_data(opcode_data),
        .step_req(step_req), .step_num(step_num), .step_axes(step_axes), .x_fwd(x_fwd),
        .x_rev(x_rev), .y_fwd(y_fwd), .y_rev(y_rev), .speed_sel(speed_sel), .run_mode(run_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq(irq)
    );
    program_store_model store (.clock(clock), .opcode_step(opcode_step), .opcode_data(opcode_data));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ends on a clock edge so callers drive pins right after it
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
        @(posedge clock);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // strobe held n cycles, then a bounded watch for the one-cycle request
    task automatic fire(input int n, input logic [2:0] exp);
        repeat (6) @(posedge clock);
        strobe_pin <= 1'b1;
        repeat (n) @(posedge clock);
        strobe_pin <= 1'b0;
        got_req = 3'h0;
        for (int k = 0; k < 40 && got_req === 3'h0; k++) begin
            @(posedge clock);
            #1;
            if (step_req !== 3'h0) got_req = step_req;
        end
        check({29'h0, got_req}, {29'h0, exp});
    endtask

    task automatic drv(input logic [3:0] exp);
        repeat (6) @(posedge clock);
        #1;
        check({28'h0, x_fwd, x_rev, y_fwd, y_rev}, {28'h0, exp});
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        results();
    end

    initial begin
        {mode_select_low, mode_select_high, jog_variant, strobe_pin} = '0;
        {axis_x_pin, axis_y_pin, stop_pin, limit_fwd_x, reg_write, reg_read} = '0;
        step_select_pins = '0;
        reg_addr = '0;
        reg_wdata = '0;
        miscompares = 0;
        total_checks = 0;
        reset_n = 1'b0; // parallel pins are the only command source
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        rd(ST, 32'h0);
        rd(MK, 32'h0);
        rd(4'hc, 32'h0);
        wr(MK, 32'hf);
        axis_x_pin <= 1'b1;
        axis_y_pin <= 1'b1;
        step_select_pins <= 6'h0a;
        fire(STROBE_LEN - 1, 3'h0);
        for (i = 0; i < 4; i++) begin
            step_select_pins <= steps[i];
            if (steps[i][2:0] == 3'h0 || steps[i][2:0] == 3'h7) begin
                fire(STROBE_LEN, 3'h0);
                rd(ST, 32'h4);
                check({31'h0, irq}, 32'h1);
                wr(ST, 32'h4);
            end else begin
                fire(STROBE_LEN, 3'h1);
                check({24'h0, step_axes, step_num}, {24'h0, 2'b11, steps[i]});
                rd(ST, 32'h1);
                wr(ST, 32'h1);
            end
            rd(ST, 32'h0);
        end
        mode_select_low <= 1'b1;
        mode_select_high <= 1'b1;
        axis_y_pin <= 1'b0;
        step_select_pins <= 6'h05;
        wr(MK, 32'h0);
        fire(STROBE_LEN, 3'h2);
        check({24'h0, step_axes, step_num}, {24'h0, 2'b01, 6'h05});
        check({31'h0, irq}, 32'h0);
        wr(MK, 32'h2);
        rd(ST, 32'h2);
        check({31'h0, irq}, 32'h1);
        wr(ST, 32'h2);
        mode_select_high <= 1'b0;
        step_select_pins <= 6'h09;
        drv(4'h8);
        check({30'h0, speed_sel}, 32'h2);
        step_select_pins <= 6'h0d;
        drv(4'h8);
        check({30'h0, speed_sel}, 32'h3);
        axis_y_pin <= 1'b1;
        step_select_pins <= 6'h0e;
        drv(4'h5);
        step_select_pins <= 6'h0f;
        drv(4'h0);
        jog_variant <= 1'b1;
        axis_y_pin <= 1'b0;
        step_select_pins <= 6'h0e;
        drv(4'h6);
        axis_x_pin <= 1'b0;
        step_select_pins <= 6'h0c;
        drv(4'h0);
        axis_y_pin <= 1'b1;
        step_select_pins <= 6'h0d;
        drv(4'h9);
        jog_variant <= 1'b0;
        mode_select_low <= 1'b0;
        mode_select_high <= 1'b1;
        axis_x_pin <= 1'b1;
        axis_y_pin <= 1'b0;
        step_select_pins <= 6'h04;
        drv(4'h0);
        step_select_pins <= 6'h05;
        repeat (4) @(posedge clock);
        step_select_pins <= 6'h04;
        drv(4'h8);
        limit_fwd_x <= 1'b1;
        drv(4'h0);
        limit_fwd_x <= 1'b0;
        step_select_pins <= 6'h06;
        repeat (4) @(posedge clock);
        step_select_pins <= 6'h04;
        drv(4'h4);
        stop_pin <= 1'b1;
        drv(4'h0);
        rd(ST, 32'h8);
        rd(4'h8, 32'h20);
        results();
    end
endmodule
